// ---- core/drs_pkg.sv ----
// constants and types shared by the dpll reference selector
// assumes one system clock and references numbered from zero
package drs_pkg;

  localparam int NUM_DPLL = 2;
  localparam int NUM_REF  = 8;
  localparam int REF_W    = 3;
  localparam int PRIO_W   = 4;
  localparam int STAT_W   = 4;
  localparam int NUM_SRC  = 5;

  // failure source positions inside each mask
  localparam int SRC_SIGNAL_ABSENCE = 0;
  localparam int SRC_SINGLE_CYCLE   = 1;
  localparam int SRC_COARSE_FREQ    = 2;
  localparam int SRC_PRECISE_FREQ   = 3;
  localparam int SRC_GUARD_SOAK     = 4;

  // priority code that keeps a reference out of selection
  localparam logic [PRIO_W-1:0] PRIO_DISABLE = 4'hF;

  // reset values
  localparam logic [REF_W-1:0]   RST_REF  = 3'h0;
  localparam logic [NUM_SRC-1:0] RST_MASK = 5'h00;

  // gray along freerun -> normal -> holdover
  typedef enum logic [1:0] {
    DRS_FREERUN  = 2'b00,
    DRS_NORMAL   = 2'b01,
    DRS_HOLDOVER = 2'b11
  } drs_state_t;

endpackage

// ---- core/drs_selector.sv ----
// reference selection and state control for every dpll of the device
// assumes monitor flags and host controls are synchronous to CLK
//
// Operation
// - automatic mode picks state and reference itself
// - managed mode follows host reference, picks state itself
// - entering automatic keeps current reference locked
// - each dpll has its own machine
// - select highest priority available, fall to next
// - switch only on failures with switch or holdover mask
// - all failed enters holdover via holdover mask
// - leave holdover once entry conditions clear
// - per dpll status shows active reference
// - priority 0 to 14, smaller preferred
// - priority 1111 excludes the reference
// - equal priority prefers lower reference index
// - priority resets to reference index
// - no revert among equals, revert to better
// - managed failure goes holdover, never auto-switch
// - failed host choice holds over until valid
// - managed holdover on any holdover-masked failure source
// - host select change passes through holdover
// - paired sync follows the selected reference
// - pairing a reference with itself disables pairing
// - status code equals reference index
// - normal and holdover flags per dpll
`timescale 1ns/1ns

module drs_selector
  import drs_pkg::*;
(
  // clock and reset
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  // reference monitor failure flags, one bit per reference
  input  wire logic [NUM_REF-1:0]           SIGNAL_ABSENCE_MONITOR_FAIL,
  input  wire logic [NUM_REF-1:0]           SINGLE_CYCLE_MONITOR_FAIL,
  input  wire logic [NUM_REF-1:0]           COARSE_FREQ_MONITOR_FAIL,
  input  wire logic [NUM_REF-1:0]           PRECISE_FREQ_MONITOR_FAIL,
  input  wire logic [NUM_REF-1:0]           GUARD_SOAK_TIMER_FAIL,
  // per dpll controls, dpll d in slice d
  input  wire logic [NUM_DPLL-1:0]          MANAGED,
  input  wire logic [NUM_DPLL*REF_W-1:0]    HOST_REF_SEL,
  input  wire logic [NUM_DPLL*NUM_SRC-1:0]  SWITCH_MASK,
  input  wire logic [NUM_DPLL*NUM_SRC-1:0]  HOLDOVER_MASK,
  // priority write port
  input  wire logic                         PRIO_WE,
  input  wire logic [NUM_DPLL-1:0]          PRIO_DPLL_SEL,
  input  wire logic [REF_W-1:0]             PRIO_REF,
  input  wire logic [PRIO_W-1:0]            PRIO_VALUE,
  // sync pair write port
  input  wire logic                         PAIR_WE,
  input  wire logic [REF_W-1:0]             PAIR_REF,
  input  wire logic [REF_W-1:0]             PAIR_VALUE,
  // per dpll status
  output logic [NUM_DPLL*STAT_W-1:0]        ACTIVE_REF,
  output logic [NUM_DPLL-1:0]               NORMAL_FLAG,
  output logic [NUM_DPLL-1:0]               HOLDOVER_FLAG,
  output logic [NUM_DPLL*REF_W-1:0]         SYNC_REF,
  output logic [NUM_DPLL-1:0]               SYNC_VALID
);

  // any enabled failure among the five sources of one reference
  function automatic logic drs_fail(input logic [NUM_SRC-1:0] src,
                                    input logic [NUM_SRC-1:0] mask);
    return |(src & mask);
  endfunction

  // best usable reference: {found, index}
  function automatic logic [REF_W:0] drs_pick(
    input logic [NUM_REF*PRIO_W-1:0] pr,
    input logic [NUM_REF-1:0]        ok
  );
    logic [REF_W:0]  res;
    logic [PRIO_W-1:0] bp;
    res = '0;
    bp  = PRIO_DISABLE;
    for (int r = 0; r < NUM_REF; r++)
    begin
      // strict compare keeps the lower index on a tie
      if (ok[r] && (!res[REF_W] || pr[r*PRIO_W +: PRIO_W] < bp))
      begin
        res = {1'b1, REF_W'(r)};
        bp  = pr[r*PRIO_W +: PRIO_W];
      end
    end
    return res;
  endfunction

  logic [NUM_REF*PRIO_W-1:0] prio [NUM_DPLL];
  logic [REF_W-1:0]          pair [NUM_REF];
  logic [NUM_SRC-1:0]        src  [NUM_REF];

  always_comb
  begin
    for (int r = 0; r < NUM_REF; r++)
    begin
      src[r] = '0;
      src[r][SRC_SIGNAL_ABSENCE] = SIGNAL_ABSENCE_MONITOR_FAIL[r];
      src[r][SRC_SINGLE_CYCLE]   = SINGLE_CYCLE_MONITOR_FAIL[r];
      src[r][SRC_COARSE_FREQ]    = COARSE_FREQ_MONITOR_FAIL[r];
      src[r][SRC_PRECISE_FREQ]   = PRECISE_FREQ_MONITOR_FAIL[r];
      src[r][SRC_GUARD_SOAK]     = GUARD_SOAK_TIMER_FAIL[r];
    end
  end

  // priority table, each entry starts at its own reference number
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int d = 0; d < NUM_DPLL; d++)
        for (int r = 0; r < NUM_REF; r++)
          prio[d][r*PRIO_W +: PRIO_W] <= PRIO_W'(r);
    end
    else if (PRIO_WE)
    begin
      for (int d = 0; d < NUM_DPLL; d++)
        if (PRIO_DPLL_SEL[d])
          prio[d][PRIO_REF*PRIO_W +: PRIO_W] <= PRIO_VALUE;
    end
  end

  // sync pair table, self pairing means no sync
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int r = 0; r < NUM_REF; r++)
        pair[r] <= REF_W'(r);
    end
    else if (PAIR_WE)
      pair[PAIR_REF] <= PAIR_VALUE;
  end

  for (genvar d = 0; d < NUM_DPLL; d++)
  begin : g_dpll
    // private decision state for this dpll only
    drs_state_t          state;
    drs_state_t          next_state;
    logic [REF_W-1:0]    cur;
    logic [REF_W-1:0]    next_cur;
    logic                no_revert;
    logic                next_no_revert;
    logic                prev_man;
    logic [NUM_REF-1:0]  sw_fail;
    logic [NUM_REF-1:0]  ho_fail;
    logic [NUM_REF-1:0]  usable;
    logic [REF_W:0]      best;
    logic [REF_W-1:0]    sel;
    logic                man;
    logic                cur_bad;
    logic                better;
    logic [STAT_W-1:0]   act_code;
    logic                in_normal;
    logic                in_holdover;
    logic [REF_W-1:0]    sync_sel;
    logic                sync_ok;

    assign man = MANAGED[d];
    assign sel = HOST_REF_SEL[d*REF_W +: REF_W];

    always_comb
    begin
      for (int r = 0; r < NUM_REF; r++)
      begin
        sw_fail[r] = drs_fail(src[r], SWITCH_MASK[d*NUM_SRC +: NUM_SRC]);
        ho_fail[r] = drs_fail(src[r], HOLDOVER_MASK[d*NUM_SRC +: NUM_SRC]);
        usable[r]  = (prio[d][r*PRIO_W +: PRIO_W] != PRIO_DISABLE)
                     && !sw_fail[r] && !ho_fail[r];
      end
    end

    assign best    = drs_pick(prio[d], usable);
    assign cur_bad = !usable[cur];
    // only a strictly better priority pulls the dpll back
    assign better  = best[REF_W] && (prio[d][best[REF_W-1:0]*PRIO_W +: PRIO_W]
                     < prio[d][cur*PRIO_W +: PRIO_W]);

    always_comb
    begin
      next_state     = state;
      next_cur       = cur;
      next_no_revert = no_revert;
      if (prev_man && !man)
        next_no_revert = 1'b1;
      if (man)
      begin
        // host owns the reference, failures only hold over
        case (state)
          DRS_FREERUN:
          begin
            next_cur = sel;
            if (!ho_fail[sel])
              next_state = DRS_NORMAL;
          end
          DRS_NORMAL:
          begin
            if (sel != cur)
            begin
              next_cur   = sel;
              next_state = DRS_HOLDOVER;
            end
            else if (ho_fail[cur])
              next_state = DRS_HOLDOVER;
          end
          DRS_HOLDOVER:
          begin
            next_cur = sel;
            if (sel == cur && !ho_fail[cur])
              next_state = DRS_NORMAL;
          end
          default:
            next_state = DRS_FREERUN;
        endcase
      end
      else
      begin
        case (state)
          DRS_FREERUN:
          begin
            if (best[REF_W])
            begin
              next_cur   = best[REF_W-1:0];
              next_state = DRS_NORMAL;
            end
          end
          DRS_NORMAL:
          begin
            if (cur_bad && best[REF_W])
            begin
              next_cur       = best[REF_W-1:0];
              next_no_revert = 1'b0;
            end
            else if (cur_bad && ho_fail[cur])
            begin
              next_state     = DRS_HOLDOVER;
              next_no_revert = 1'b0;
            end
            else if (cur_bad)
              next_no_revert = 1'b0;
            // the first cycle after leaving managed mode must not revert either
            else if (better && !no_revert && !prev_man)
              next_cur = best[REF_W-1:0];
          end
          DRS_HOLDOVER:
          begin
            if (best[REF_W])
            begin
              next_cur   = best[REF_W-1:0];
              next_state = DRS_NORMAL;
            end
          end
          default:
            next_state = DRS_FREERUN;
        endcase
      end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        state     <= DRS_FREERUN;
        cur       <= RST_REF;
        no_revert <= 1'b0;
        prev_man  <= 1'b0;
      end
      else
      begin
        state     <= next_state;
        cur       <= next_cur;
        no_revert <= next_no_revert;
        prev_man  <= man;
      end
    end

    // registered status
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        act_code    <= '0;
        in_normal   <= 1'b0;
        in_holdover <= 1'b0;
      end
      else
      begin
        act_code    <= STAT_W'(next_cur);
        in_normal   <= (next_state == DRS_NORMAL);
        in_holdover <= (next_state == DRS_HOLDOVER);
      end
    end

    // sync input travels with the selected clock reference
    always_ff @(posedge CLK or negedge NRST)
    begin
      if (!NRST)
      begin
        sync_sel <= RST_REF;
        sync_ok  <= 1'b0;
      end
      else
      begin
        sync_sel <= pair[next_cur];
        sync_ok  <= (next_state == DRS_NORMAL)
                    && (pair[next_cur] != next_cur);
      end
    end

    // each dpll owns its slice through a plain assign, so no bit has two processes
    assign ACTIVE_REF[d*STAT_W +: STAT_W] = act_code;
    assign NORMAL_FLAG[d]                 = in_normal;
    assign HOLDOVER_FLAG[d]               = in_holdover;
    assign SYNC_REF[d*REF_W +: REF_W]     = sync_sel;
    assign SYNC_VALID[d]                  = sync_ok;
  end

endmodule

// ---- testbench/drs_selector_props.sv ----
// port assertions for the reference selector, dpll0 and shared flags
// bound to drs_selector from the bench top file
`timescale 1ns/1ns
module drs_selector_props
  import drs_pkg::*;
(
  // clock and reset
  input wire logic                        CLK,
  input wire logic                        NRST,
  // monitor flags
  input wire logic [NUM_REF-1:0]          SIGNAL_ABSENCE_MONITOR_FAIL,
  input wire logic [NUM_REF-1:0]          SINGLE_CYCLE_MONITOR_FAIL,
  input wire logic [NUM_REF-1:0]          COARSE_FREQ_MONITOR_FAIL,
  input wire logic [NUM_REF-1:0]          PRECISE_FREQ_MONITOR_FAIL,
  input wire logic [NUM_REF-1:0]          GUARD_SOAK_TIMER_FAIL,
  // controls
  input wire logic [NUM_DPLL-1:0]         MANAGED,
  input wire logic [NUM_DPLL*REF_W-1:0]   HOST_REF_SEL,
  input wire logic [NUM_DPLL*NUM_SRC-1:0] HOLDOVER_MASK,
  // status
  input wire logic [NUM_DPLL*STAT_W-1:0]  ACTIVE_REF,
  input wire logic [NUM_DPLL-1:0]         NORMAL_FLAG,
  input wire logic [NUM_DPLL-1:0]         HOLDOVER_FLAG,
  input wire logic [NUM_DPLL*REF_W-1:0]   SYNC_REF,
  input wire logic [NUM_DPLL-1:0]         SYNC_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // refs holding a holdover-enabled failure for dpll0
  logic [NUM_REF-1:0] hf;
  always_comb
  begin
    hf = (SIGNAL_ABSENCE_MONITOR_FAIL & {NUM_REF{HOLDOVER_MASK[0]}})
       | (SINGLE_CYCLE_MONITOR_FAIL & {NUM_REF{HOLDOVER_MASK[1]}})
       | (COARSE_FREQ_MONITOR_FAIL & {NUM_REF{HOLDOVER_MASK[2]}})
       | (PRECISE_FREQ_MONITOR_FAIL & {NUM_REF{HOLDOVER_MASK[3]}})
       | (GUARD_SOAK_TIMER_FAIL & {NUM_REF{HOLDOVER_MASK[4]}});
  end
  sequence s_mgd;
    MANAGED[0] && $past(MANAGED[0]);
  endsequence
  sequence s_sel_chg;
    s_mgd ##0 (NORMAL_FLAG[0] && $changed(HOST_REF_SEL[2:0]));
  endsequence
  flags_excl_a: assert property ((NORMAL_FLAG & HOLDOVER_FLAG) == '0)
    else $error("normal and holdover both set");
  code_top_a: assert property (!ACTIVE_REF[3] && !ACTIVE_REF[7])
    else $error("active ref code above seven");
  sync_norm_a: assert property (SYNC_VALID[0] |-> NORMAL_FLAG[0])
    else $error("sync valid outside normal");
  sync_self_a: assert property (SYNC_VALID[0] |-> SYNC_REF[2:0] != ACTIVE_REF[2:0])
    else $error("self pairing reported valid");
  sel_chg_a: assert property (s_sel_chg |=> HOLDOVER_FLAG[0]
    && ACTIVE_REF[2:0] == $past(HOST_REF_SEL[2:0])) else $error("host change skipped holdover");
  host_lock_a: assert property (s_mgd ##0 (HOLDOVER_FLAG[0] && $stable(HOST_REF_SEL[2:0])
    && !hf[HOST_REF_SEL[2:0]]) |=> NORMAL_FLAG[0]) else $error("no lock on good host ref");
  // a host change in the same cycle moves the reference on purpose, so it is left to sel_chg_a
  host_fail_a: assert property (s_mgd ##0 (NORMAL_FLAG[0] && $stable(HOST_REF_SEL[2:0])
    && hf[HOST_REF_SEL[2:0]]) |=> HOLDOVER_FLAG[0] && $stable(ACTIVE_REF[2:0]))
    else $error("host ref fail not held");
  all_fail_a: assert property (NORMAL_FLAG[0] && (&hf) |=> HOLDOVER_FLAG[0])
    else $error("all refs failed without holdover");
endmodule

// ---- testbench/drs_ref_monitors.sv ----
// reference monitor stand-in: one chosen monitor flags the bad refs
// slice k of flags is monitor k in package source order
`timescale 1ns/1ns
module drs_ref_monitors
  import drs_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // fault scenario
  input  wire logic [NUM_REF-1:0]         bad,
  input  wire logic [2:0]                 src,
  // monitor flags
  output logic      [NUM_SRC*NUM_REF-1:0] flags
);
  // registered like a real monitor, so flags lag the scenario by one edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flags <= '0;
    else
      flags <= {32'h0, bad} << (src * NUM_REF);
  end
endmodule

// ---- testbench/tb_dpll_reference_selector.sv ----
// self-checking bench: random priorities and faults, then mask, managed
// and pairing corners; dpll1 stays host-directed on ref2 throughout
`timescale 1ns/1ns
module tb_dpll_reference_selector
  import drs_pkg::*;
();
  logic                        clk, nrst, prio_we, pair_we, e_norm;
  logic [NUM_REF-1:0]          bad, nb;
  logic [2:0]                  src, prio_ref, pair_ref, pair_value, e_ref;
  logic [NUM_SRC*NUM_REF-1:0]  fl;
  logic [NUM_DPLL-1:0]         managed, prio_dpll_sel, normal_flag, holdover_flag, sync_valid;
  logic [NUM_DPLL*REF_W-1:0]   host_ref_sel, sync_ref;
  logic [NUM_DPLL*NUM_SRC-1:0] switch_mask, holdover_mask;
  logic [PRIO_W-1:0]           prio_value;
  logic [PRIO_W-1:0]           pr [NUM_REF];
  logic [NUM_DPLL*STAT_W-1:0]  active_ref;
  logic [31:0]                 rnd;
  int                          err_count, comparisons;
  // settled copies of the outputs, taken mid-cycle so checks never race an edge
  logic [NUM_DPLL*STAT_W-1:0]  act_s;
  logic [NUM_DPLL*REF_W-1:0]   sref_s;
  logic [NUM_DPLL-1:0]         norm_s, hold_s, sval_s;

  drs_ref_monitors u_mon (.clk(clk), .nrst(nrst), .bad(bad), .src(src), .flags(fl));
  drs_selector u_drs_selector (.CLK(clk), .NRST(nrst), .SIGNAL_ABSENCE_MONITOR_FAIL(fl[7:0]),
    .SINGLE_CYCLE_MONITOR_FAIL(fl[15:8]), .COARSE_FREQ_MONITOR_FAIL(fl[23:16]),
    .PRECISE_FREQ_MONITOR_FAIL(fl[31:24]), .GUARD_SOAK_TIMER_FAIL(fl[39:32]),
    .MANAGED(managed), .HOST_REF_SEL(host_ref_sel), .SWITCH_MASK(switch_mask),
    .HOLDOVER_MASK(holdover_mask), .PRIO_WE(prio_we), .PRIO_DPLL_SEL(prio_dpll_sel),
    .PRIO_REF(prio_ref), .PRIO_VALUE(prio_value), .PAIR_WE(pair_we), .PAIR_REF(pair_ref),
    .PAIR_VALUE(pair_value), .ACTIVE_REF(active_ref), .NORMAL_FLAG(normal_flag),
    .HOLDOVER_FLAG(holdover_flag), .SYNC_REF(sync_ref), .SYNC_VALID(sync_valid));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // best usable ref of dpll0; the current one wins unless strictly beaten
  function automatic logic [3:0] best(input logic [7:0] ok);
    logic [3:0] b;
    b = 4'h8;
    for (int r = 0; r < NUM_REF; r++)
      if (ok[r] && pr[r] != PRIO_DISABLE && (b[3] || pr[r] < pr[b[2:0]]))
        b = r[3:0];
    if (e_norm && ok[e_ref] && pr[e_ref] != PRIO_DISABLE && !(pr[b[2:0]] < pr[e_ref]))
      b = {1'b0, e_ref};
    return b;
  endfunction
  task automatic upd(input logic [7:0] ok);
    logic [3:0] b;
    b = best(ok);
    e_norm = !b[3];
    if (!b[3])
      e_ref = b[2:0];
  endtask
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (!ok)
    begin
      err_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    cyc(8);
    nrst <= 1'b1;
    for (int r = 0; r < NUM_REF; r++)
      pr[r] = r[3:0];
    e_ref = 3'h0;
    e_norm = 1'b1;
  endtask
  task automatic wr_prio(input logic [1:0] d, input logic [2:0] r, input logic [3:0] v);
    prio_we <= 1'b1;
    prio_dpll_sel <= d;
    prio_ref <= r;
    prio_value <= v;
    cyc(1);
    prio_we <= 1'b0;
    cyc(1);
    if (d[0])
      pr[r] = v;
  endtask
  task automatic pair(input logic [2:0] r, input logic [2:0] v);
    pair_we <= 1'b1;
    pair_ref <= r;
    pair_value <= v;
    cyc(1);
    pair_we <= 1'b0;
    cyc(3);
  endtask
  task automatic step(input logic [7:0] b, input logic [2:0] s, input logic [2:0] er,
                      input logic en);
    bad <= b;
    src <= s;
    cyc(5);
    check(act_s[3:0] === {1'b0, er} && norm_s[0] === en
          && hold_s[0] === !en, "dpll0 state");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk)
  begin
    act_s  <= active_ref;
    sref_s <= sync_ref;
    norm_s <= normal_flag;
    hold_s <= holdover_flag;
    sval_s <= sync_valid;
  end
  // generous bound: the run needs under 2000 cycles
  initial
  begin
    #(8 * 20000);
    err_count++;
    give_verdict;
  end
  initial
  begin
    {nrst, prio_we, pair_we, bad, src, prio_ref, pair_ref, pair_value} = '0;
    {prio_dpll_sel, prio_value} = '0;
    managed = 2'b10;
    host_ref_sel = 6'h10;
    switch_mask = 10'h3FF;
    holdover_mask = 10'h3FF;
    rnd = 32'h9FDF;
    do_reset;
    cyc(3);
    check(norm_s === 2'b11 && hold_s === 2'b00 && act_s === 8'h20,
          "start lock");
    wr_prio(2'b11, 3'h7, PRIO_DISABLE);
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      wr_prio(2'b01, (rnd[2:0] == 3'h7) ? 3'h6 : rnd[2:0], {1'b0, rnd[5:3]});
      upd(~bad);
      step(bad, src, e_ref, e_norm);
      nb = (rnd[26:24] == 3'h0) ? 8'hFF : rnd[15:8] & rnd[23:16];
      upd(~nb);
      step(nb, (rnd[31:29] > 3'h4) ? 3'h4 : rnd[31:29], e_ref, e_norm);
      check(norm_s[1] === !nb[2] && hold_s[1] === nb[2] && act_s[7:4] === 4'h2,
            "dpll1 host");
    end
    do_reset;
    wr_prio(2'b11, 3'h7, PRIO_DISABLE);
    for (int s = 0; s < NUM_SRC; s++)
    begin
      switch_mask[4:0] <= 5'h01 << s;
      holdover_mask[4:0] <= 5'h00;
      step(8'h00, s[2:0], 3'h0, 1'b1);
      step(8'h01, s[2:0], 3'h1, 1'b1);
      step(8'h00, s[2:0], 3'h0, 1'b1);
      step(8'h01, (s == 4) ? 3'h0 : 3'(s + 1), 3'h0, 1'b1);
      switch_mask[4:0] <= 5'h00;
      holdover_mask[4:0] <= 5'h01 << s;
      step(8'hFF, (s == 4) ? 3'h0 : 3'(s + 1), 3'h0, 1'b1);
      step(8'hFF, s[2:0], 3'h0, 1'b0);
      step(8'hFE, s[2:0], 3'h0, 1'b1);
    end
    switch_mask[4:0] <= 5'h1F;
    holdover_mask[4:0] <= 5'h1F;
    managed[0] <= 1'b1;
    host_ref_sel[2:0] <= 3'h3;
    step(8'h00, 3'h0, 3'h3, 1'b1);
    host_ref_sel[2:0] <= 3'h5;
    step(8'h20, 3'h3, 3'h5, 1'b0);
    step(8'h00, 3'h3, 3'h5, 1'b1);
    step(8'h20, 3'h2, 3'h5, 1'b0);
    step(8'h00, 3'h1, 3'h5, 1'b1);
    managed[0] <= 1'b0;
    step(8'h00, 3'h0, 3'h5, 1'b1);
    step(8'h20, 3'h4, 3'h0, 1'b1);
    pair(3'h0, 3'h7);
    check(sval_s === 2'b01 && sref_s === 6'h17, "sync pair");
    pair(3'h0, 3'h0);
    check(sval_s === 2'b00 && sref_s === 6'h10, "sync self");
    give_verdict;
  end
endmodule

bind drs_selector drs_selector_props u_drs_selector_props (.CLK(CLK), .NRST(NRST),
  .SIGNAL_ABSENCE_MONITOR_FAIL(SIGNAL_ABSENCE_MONITOR_FAIL),
  .SINGLE_CYCLE_MONITOR_FAIL(SINGLE_CYCLE_MONITOR_FAIL),
  .COARSE_FREQ_MONITOR_FAIL(COARSE_FREQ_MONITOR_FAIL),
  .PRECISE_FREQ_MONITOR_FAIL(PRECISE_FREQ_MONITOR_FAIL),
  .GUARD_SOAK_TIMER_FAIL(GUARD_SOAK_TIMER_FAIL), .MANAGED(MANAGED),
  .HOST_REF_SEL(HOST_REF_SEL), .HOLDOVER_MASK(HOLDOVER_MASK), .ACTIVE_REF(ACTIVE_REF),
  .NORMAL_FLAG(NORMAL_FLAG), .HOLDOVER_FLAG(HOLDOVER_FLAG), .SYNC_REF(SYNC_REF),
  .SYNC_VALID(SYNC_VALID));
